/* File: verilog/irq_map_pkg.sv */
// constants, field layout and reset values of the interrupt request map
// assumes one machine clock domain; shared by the map module and the bench

package irq_map_pkg;

    // request line geometry
    localparam int NUM_LINES      = 24;
    localparam int LINE_IDX_W     = 5;
    localparam int LEVEL_W        = 2;
    localparam int LINES_PER_REG  = 4;
    localparam int NUM_LEVEL_REGS = 6;
    localparam int LEVEL_REG_W    = 8;
    localparam int REG_IDX_W      = 3;
    localparam int EXT_CHANNELS   = 8;
    localparam int EXT_SHARED     = 4;

    // vector table: line 0 at the top, each line two bytes lower
    localparam int          VEC_W        = 16;
    localparam logic [15:0] VEC_TOP      = 16'hFFFA;
    localparam logic [15:0] VEC_BOTTOM   = 16'hFFCC;
    localparam int          VEC_STEP     = 2;
    localparam logic [15:0] VEC_LOWER_OF = 16'h0001;

    // level reset value: every field at the weakest level
    localparam logic [7:0]  LEVEL_REG_RESET = 8'hFF;
    localparam logic [1:0]  CPU_LEVEL_NONE  = 2'h3;

    // fixed line assignment of the shared and single sources
    localparam int LINE_SERIAL0      = 4;
    localparam int LINE_COMP0_LO     = 5;
    localparam int LINE_COMP0_HI     = 6;
    localparam int LINE_LIN_RX       = 7;
    localparam int LINE_LIN_TX       = 8;
    localparam int LINE_PULSE1_LO    = 9;
    localparam int LINE_PULSE1_HI    = 10;
    localparam int LINE_PULSE2_HI    = 11;
    localparam int LINE_PULSE0_HI    = 12;
    localparam int LINE_PULSE0_LO    = 13;
    localparam int LINE_COMP1_HI     = 14;
    localparam int LINE_PULSE2_LO    = 15;
    localparam int LINE_RELOAD       = 16;
    localparam int LINE_PULSE_TIMER  = 17;
    localparam int LINE_CONVERTER    = 18;
    localparam int LINE_TIME_BASE    = 19;
    localparam int LINE_WATCH        = 20;
    localparam int LINE_COMPARATOR1  = 21;
    localparam int LINE_COMP1_LO     = 22;
    localparam int LINE_FLASH        = 23;

    typedef logic [LEVEL_REG_W-1:0] level_reg_type;

    typedef struct packed {
        level_reg_type [NUM_LEVEL_REGS-1:0] levelRegs;
        logic [NUM_LINES-1:0]               lines;
        logic                               valid;
        logic [LINE_IDX_W-1:0]              line;
        logic [LEVEL_W-1:0]                 level;
        logic [VEC_W-1:0]                   vecUpper;
        logic [VEC_W-1:0]                   vecLower;
        logic                               pending;
        level_reg_type                      rdData;
    } map_state_type;

endpackage

/* File: verilog/interrupt_vector_priority_map.sv */
// interrupt request map: gathers peripheral requests onto 24 lines,
// holds the six level registers and picks the line to vector to.
// assumes all request inputs are synchronous levels on clk
// assumes each peripheral holds its request level until software clears it
// assumes the cpu takes irqPending, irqLine and the vector pair as one set

`timescale 1ns/1ps

module interrupt_vector_priority_map
    import irq_map_pkg::*;
(
    // clock, reset, enable
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   clkEn,
    // external interrupt channels
    input  wire logic [EXT_CHANNELS-1:0] extInt,
    // serial and motor pulse generator sources
    input  wire logic                   clockedSerial0,
    input  wire logic                   deadTimeTrip,
    input  wire logic                   motorWriteCompare,
    input  wire logic                   motorPosition,
    // timers
    input  wire logic                   compTimer0Lo,
    input  wire logic                   compTimer0Hi,
    input  wire logic                   compTimer1Lo,
    input  wire logic                   compTimer1Hi,
    input  wire logic                   pulseUnit0Lo,
    input  wire logic                   pulseUnit0Hi,
    input  wire logic                   pulseUnit1Lo,
    input  wire logic                   pulseUnit1Hi,
    input  wire logic                   pulseUnit2Lo,
    input  wire logic                   pulseUnit2Hi,
    input  wire logic                   reloadTimer,
    input  wire logic                   pulseTimer16,
    input  wire logic                   timeBase,
    input  wire logic                   watchPrescaler,
    // communication, analog and memory sources
    input  wire logic                   linRx,
    input  wire logic                   linTx,
    input  wire logic                   twoWireBus,
    input  wire logic                   converterDone,
    input  wire logic                   comparator0,
    input  wire logic                   comparator1,
    input  wire logic                   flashMemory,
    // level register access
    input  wire logic                   levelWrEn,
    input  wire logic [REG_IDX_W-1:0]   levelWrIdx,
    input  wire logic [LEVEL_REG_W-1:0] levelWrData,
    input  wire logic [REG_IDX_W-1:0]   levelRdIdx,
    output logic      [LEVEL_REG_W-1:0] levelRdData,
    // cpu side
    input  wire logic [LEVEL_W-1:0]     cpuLevel,
    output logic      [NUM_LINES-1:0]   requestLines,
    output logic                        irqValid,
    output logic                        irqPending,
    output logic      [LINE_IDX_W-1:0]  irqLine,
    output logic      [LEVEL_W-1:0]     irqLevel,
    output logic      [VEC_W-1:0]       vectorUpper,
    output logic      [VEC_W-1:0]       vectorLower
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    map_state_type state_ff;
    map_state_type nxt_state;

    // reset image: every field at the weakest level, idle outputs on line 0
    // the vector pair stays well defined even while irqValid is low
    localparam map_state_type STATE_RESET = '{
        levelRegs: {NUM_LEVEL_REGS{LEVEL_REG_RESET}},
        lines:     '0,
        valid:     1'b0,
        line:      '0,
        level:     CPU_LEVEL_NONE,
        vecUpper:  VEC_TOP,
        vecLower:  VEC_TOP + VEC_LOWER_OF,
        pending:   1'b0,
        rdData:    '0
    };

    ////////////////////////////////////////////////////////////////////////////
    // per-line level fields and vector addresses

    logic [LEVEL_W-1:0] lineLevel [NUM_LINES];
    logic [VEC_W-1:0]   lineUpper [NUM_LINES];
    logic [VEC_W-1:0]   lineLower [NUM_LINES];

    for (genvar g = 0; g < NUM_LINES; g++) begin : gen_line
        // field layout inside a register is our own: line g at bits 2*(g%4) up
        assign lineLevel[g] = state_ff.levelRegs[g / LINES_PER_REG][(g % LINES_PER_REG) * LEVEL_W +: LEVEL_W];
        // fixed table, so each address folds to a constant
        assign lineUpper[g] = VEC_TOP - VEC_W'(VEC_STEP * g);
        assign lineLower[g] = lineUpper[g] + VEC_LOWER_OF;
    end

    ////////////////////////////////////////////////////////////////////////////
    // level register readback

    // absent registers read as zero rather than aliasing a present one
    level_reg_type rdMux [2**REG_IDX_W];

    for (genvar r = 0; r < 2**REG_IDX_W; r++) begin : gen_rd
        if (r < NUM_LEVEL_REGS) begin : gen_present
            assign rdMux[r] = state_ff.levelRegs[r];
        end else begin : gen_absent
            assign rdMux[r] = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // arbitration on the registered lines

    // ripple from line 0 upward: only a strictly smaller level value takes over,
    // so on a tie the lowest line keeps the win; slower than a tree, but the
    // tie rule is plain to see and the depth is one stage per line
    logic                  arbFound [NUM_LINES+1];
    logic [LINE_IDX_W-1:0] arbLine  [NUM_LINES+1];
    logic [LEVEL_W-1:0]    arbLevel [NUM_LINES+1];

    assign arbFound[0] = 1'b0;
    assign arbLine[0]  = '0;
    assign arbLevel[0] = CPU_LEVEL_NONE;

    for (genvar g = 0; g < NUM_LINES; g++) begin : gen_arb
        logic take;

        assign take          = state_ff.lines[g] && (!arbFound[g] || (lineLevel[g] < arbLevel[g]));
        assign arbFound[g+1] = arbFound[g] || take;
        assign arbLine[g+1]  = take ? LINE_IDX_W'(g) : arbLine[g];
        assign arbLevel[g+1] = take ? lineLevel[g] : arbLevel[g];
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [NUM_LINES-1:0]  req;

        req       = '0;
        nxt_state = state_ff;

        // sources onto lines; shared lines are plain ors
        for (int n = 0; n < EXT_SHARED; n++) begin
            req[n] = extInt[n] | extInt[n + EXT_SHARED];
        end
        req[LINE_SERIAL0]     = clockedSerial0 | deadTimeTrip;
        req[LINE_COMP0_LO]    = compTimer0Lo;
        req[LINE_COMP0_HI]    = compTimer0Hi;
        req[LINE_LIN_RX]      = linRx;
        req[LINE_LIN_TX]      = linTx;
        req[LINE_PULSE1_LO]   = pulseUnit1Lo;
        req[LINE_PULSE1_HI]   = pulseUnit1Hi;
        req[LINE_PULSE2_HI]   = pulseUnit2Hi;
        req[LINE_PULSE0_HI]   = pulseUnit0Hi;
        req[LINE_PULSE0_LO]   = pulseUnit0Lo;
        req[LINE_COMP1_HI]    = compTimer1Hi;
        req[LINE_PULSE2_LO]   = pulseUnit2Lo;
        req[LINE_RELOAD]      = reloadTimer | motorWriteCompare | twoWireBus;
        req[LINE_PULSE_TIMER] = pulseTimer16 | motorPosition;
        req[LINE_CONVERTER]   = converterDone;
        req[LINE_TIME_BASE]   = timeBase;
        req[LINE_WATCH]       = watchPrescaler | comparator0;
        req[LINE_COMPARATOR1] = comparator1;
        req[LINE_COMP1_LO]    = compTimer1Lo;
        req[LINE_FLASH]       = flashMemory;
        nxt_state.lines       = req;

        // level registers; out-of-range index writes are dropped
        // a write lands at this edge; the ripple uses it from the next one
        if (levelWrEn && (int'(levelWrIdx) < NUM_LEVEL_REGS)) begin
            nxt_state.levelRegs[levelWrIdx] = levelWrData;
        end
        // readback is registered: it shows the index sampled one edge earlier
        nxt_state.rdData = rdMux[levelRdIdx];

        // registered lines feed the ripple, so the winner trails its request by one edge
        nxt_state.valid    = arbFound[NUM_LINES];
        nxt_state.line     = arbLine[NUM_LINES];
        nxt_state.level    = arbLevel[NUM_LINES];
        nxt_state.vecUpper = lineUpper[arbLine[NUM_LINES]];
        nxt_state.vecLower = lineLower[arbLine[NUM_LINES]];
        // cpu takes only a level stronger than the one it runs at
        nxt_state.pending  = arbFound[NUM_LINES] && (arbLevel[NUM_LINES] < cpuLevel);
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= STATE_RESET;
        end else if (clkEn) begin
            // clkEn low freezes every field, outputs and level registers alike
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // every output comes straight from a flip-flop, none from the source pins
    assign levelRdData  = state_ff.rdData;
    assign requestLines = state_ff.lines;
    assign irqValid     = state_ff.valid;
    assign irqPending   = state_ff.pending;
    assign irqLine      = state_ff.line;
    assign irqLevel     = state_ff.level;
    assign vectorUpper  = state_ff.vecUpper;
    assign vectorLower  = state_ff.vecLower;

endmodule // interrupt_vector_priority_map

/* File: verification/interrupt_vector_priority_map_sva.sv */
// checker for the request map, watching the top ports only
// assumes one clock domain, reset_n async active low
`timescale 1ns/1ps
module interrupt_vector_priority_map_sva (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        clkEn,
    input wire logic [7:0]  extInt,
    input wire logic [2:0]  levelRdIdx,
    input wire logic [7:0]  levelRdData,
    input wire logic [1:0]  cpuLevel,
    input wire logic [23:0] requestLines,
    input wire logic        irqValid,
    input wire logic        irqPending,
    input wire logic [4:0]  irqLine,
    input wire logic [1:0]  irqLevel,
    input wire logic [15:0] vectorUpper,
    input wire logic [15:0] vectorLower
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_vec; irqValid |-> vectorUpper == 16'hFFFA - {irqLine, 1'b0}; endproperty
    a_vec: assert property (p_vec) else $error("vector does not match line");
    property p_pair; vectorLower == vectorUpper + 16'h0001; endproperty
    a_pair: assert property (p_pair) else $error("lower vector not next byte");
    property p_none; !irqValid |-> irqLine == 5'h00 && irqLevel == 2'h3 && vectorUpper == 16'hFFFA; endproperty
    a_none: assert property (p_none) else $error("idle outputs wrong");
    property p_share; clkEn |=> requestLines[0] == $past(extInt[0] | extInt[4]); endproperty
    a_share: assert property (p_share) else $error("line 0 not shared by channels 0 and 4");
    property p_any; clkEn |=> irqValid == |$past(requestLines); endproperty
    a_any: assert property (p_any) else $error("valid not tied to request lines");
    property p_win; clkEn ##1 irqValid |-> (($past(requestLines) >> irqLine) & 24'h1) == 24'h1; endproperty
    a_win: assert property (p_win) else $error("winning line was not requesting");
    property p_pend; clkEn |=> irqPending == (irqValid && irqLevel < $past(cpuLevel)); endproperty
    a_pend: assert property (p_pend) else $error("pending against cpu level wrong");
    property p_rd; clkEn && levelRdIdx > 3'h5 |=> levelRdData == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("absent level register reads nonzero");
    property p_hold; !clkEn |=> $stable(requestLines) && $stable(vectorUpper); endproperty
    a_hold: assert property (p_hold) else $error("state moved while frozen");
    c_pend: cover property (irqPending);
    c_last: cover property (irqValid && irqLine == 5'h17);
    c_hold: cover property (!clkEn);
endmodule // interrupt_vector_priority_map_sva
bind interrupt_vector_priority_map interrupt_vector_priority_map_sva interrupt_vector_priority_map_sva_inst (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .extInt(extInt), .levelRdIdx(levelRdIdx),
    .levelRdData(levelRdData), .cpuLevel(cpuLevel), .requestLines(requestLines), .irqValid(irqValid),
    .irqPending(irqPending), .irqLine(irqLine), .irqLevel(irqLevel), .vectorUpper(vectorUpper),
    .vectorLower(vectorLower));

/* File: verification/cpu_core_model.sv */
// cpu core model: runs at a chosen level, fetches the vector of a pending request
// assumes vectors are settled at the edge where pending is seen
`timescale 1ns/1ps
module cpu_core_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // level and fetch
    input  wire logic [1:0]  runLevel,
    output logic      [1:0]  cpuLevel,
    input  wire logic        irqPending,
    input  wire logic [15:0] vectorUpper,
    output logic      [15:0] vecFetch_ff
);
    assign cpuLevel = runLevel;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) vecFetch_ff <= 16'h0000;
        else if (irqPending) vecFetch_ff <= vectorUpper;
    end
endmodule // cpu_core_model

/* File: verification/interrupt_vector_priority_map_test.sv */
// self-checking bench: per-source walk, random sources, levels and cpu level
// assumes the cpu model fetches one edge after pending
`timescale 1ns/1ps
module interrupt_vector_priority_map_test;
    import irq_map_pkg::*;
    logic        clk, reset_n, clkEn, levelWrEn, v, p;
    logic [32:0] s;
    logic [2:0]  wi, ri;
    logic [7:0]  wd, rd, expRd;
    logic [1:0]  runLevel, cpuLevel, lv;
    logic [23:0] rl, e;
    logic [4:0]  il;
    logic [15:0] vu, vl, fetched;
    logic [7:0]  lr[6];
    int          num_errors, n_tests, bl, bv;
    interrupt_vector_priority_map interrupt_vector_priority_map_inst (
        .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .extInt(s[7:0]), .clockedSerial0(s[8]), .deadTimeTrip(s[9]),
        .compTimer0Lo(s[10]), .compTimer0Hi(s[11]), .linRx(s[12]), .linTx(s[13]), .pulseUnit1Lo(s[14]),
        .pulseUnit1Hi(s[15]), .pulseUnit2Hi(s[16]), .pulseUnit0Hi(s[17]), .pulseUnit0Lo(s[18]),
        .compTimer1Hi(s[19]), .pulseUnit2Lo(s[20]), .reloadTimer(s[21]), .motorWriteCompare(s[22]),
        .twoWireBus(s[23]), .pulseTimer16(s[24]), .motorPosition(s[25]), .converterDone(s[26]), .timeBase(s[27]),
        .watchPrescaler(s[28]), .comparator0(s[29]), .comparator1(s[30]), .compTimer1Lo(s[31]), .flashMemory(s[32]),
        .levelWrEn(levelWrEn), .levelWrIdx(wi), .levelWrData(wd), .levelRdIdx(ri), .levelRdData(rd),
        .cpuLevel(cpuLevel), .requestLines(rl), .irqValid(v), .irqPending(p), .irqLine(il), .irqLevel(lv),
        .vectorUpper(vu), .vectorLower(vl));
    cpu_core_model cpu_core_model_inst (.clk(clk), .reset_n(reset_n), .runLevel(runLevel), .cpuLevel(cpuLevel),
        .irqPending(p), .vectorUpper(vu), .vecFetch_ff(fetched));
    ////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [23:0] x, logic [23:0] g);
        n_tests++;
        if (g !== x) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    // every output at its idle value while reset is held
    task automatic chk_reset;
        chk("reset requestLines", 24'h000000, rl);
        chk("reset irqValid", 24'h000000, 24'(v));
        chk("reset irqPending", 24'h000000, 24'(p));
        chk("reset irqLine", 24'h000000, 24'(il));
        chk("reset irqLevel", 24'(CPU_LEVEL_NONE), 24'(lv));
        chk("reset vectorUpper", 24'(VEC_TOP), 24'(vu));
        chk("reset vectorLower", 24'(VEC_TOP + VEC_LOWER_OF), 24'(vl));
        chk("reset levelRdData", 24'h000000, 24'(rd));
    endtask
    // entered at a falling edge; one transfer takes three cycles
    task automatic step(logic [32:0] src, logic we, logic [2:0] idx, logic [7:0] d, logic [1:0] cl);
        s = src; levelWrEn = we; wi = idx; wd = d; ri = idx; runLevel = cl;
        expRd = idx < 3'h6 ? lr[idx] : 8'h00;
        if (we && idx < 3'h6) lr[idx] = d;
        for (int n = 0; n < 4; n++) e[n] = src[n] | src[n+4];
        e[4] = src[8] | src[9];
        for (int n = 5; n < 16; n++) e[n] = src[n+5];
        e[16] = |src[23:21];
        e[17] = |src[25:24];
        e[20:18] = {|src[29:28], src[27:26]};
        e[23:21] = src[32:30];
        bv = 3; bl = 0;
        for (int n = 23; n >= 0; n--) if (e[n] && lr[n/4][2*(n%4)+:2] <= bv) begin
            bv = lr[n/4][2*(n%4)+:2]; bl = n;
        end
        @(negedge clk);
        levelWrEn = 1'b0;
        chk("requestLines", e, rl);
        chk("levelRdData", 24'(expRd), 24'(rd));
        @(negedge clk);
        chk("irqValid", 24'(|e), 24'(v));
        chk("irqLine", 24'(bl), 24'(il));
        chk("irqLevel", 24'(bv), 24'(lv));
        chk("vectorUpper", 24'(16'hFFFA - 16'(2*bl)), 24'(vu));
        chk("vectorLower", 24'(16'hFFFB - 16'(2*bl)), 24'(vl));
        chk("irqPending", 24'(|e && bv < cl), 24'(p));
        @(negedge clk);
        if (|e && bv < cl) chk("fetched", 24'(16'hFFFA - 16'(2*bl)), 24'(fetched));
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        reset_n = 0; clkEn = 1; s = '0; levelWrEn = 0; wi = 0; wd = 0; ri = 0; runLevel = 0;
        num_errors = 0; n_tests = 0;
        foreach (lr[i]) lr[i] = 8'hFF;
        void'($urandom(84582));
        repeat (16) @(negedge clk);
        chk_reset;
        reset_n = 1'b1;
        for (int i = 0; i < 33; i++) step(33'h1 << i, 1'b0, 3'(i % 8), 8'h00, 2'h3);
        step({33{1'b1}}, 1'b1, 3'h6, 8'h00, 2'h3);
        for (int i = 0; i < 300; i++) step(33'({$urandom, $urandom} & {$urandom, $urandom}), 1'($urandom),
            3'($urandom), 8'($urandom), 2'($urandom));
        // mid-run reset: outputs idle again, every level back to the weakest
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        chk_reset;
        reset_n = 1'b1;
        foreach (lr[i]) lr[i] = LEVEL_REG_RESET;
        for (int i = 0; i < NUM_LEVEL_REGS; i++) step({33{1'b1}}, 1'b0, 3'(i), 8'h00, 2'h2);
        // frozen enable must hold the outputs; request lines, irqLine and vectorLower are checked
        clkEn = 1'b0;
        s = ~s;
        repeat (3) @(negedge clk);
        chk("frozen requestLines", e, rl);
        chk("frozen irqLine", 24'(bl), 24'(il));
        chk("frozen vectorLower", 24'(16'hFFFB - 16'(2*bl)), 24'(vl));
        clkEn = 1'b1;
        finish_test;
    end
endmodule // interrupt_vector_priority_map_test
